/* File: hdl/apss_pkg.sv */
// package: register map, field layout, reset values and timing constants of the strobe sequencer
package apss_pkg;

	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFS_TIM0 = 8'h00;
	localparam logic [7:0] OFS_TIM1 = 8'h04;
	localparam logic [7:0] OFS_TIM2 = 8'h08;
	localparam logic [7:0] OFS_TIM3 = 8'h0C;
	localparam logic [7:0] OFS_CMD = 8'h10;
	localparam logic [7:0] OFS_WDATA = 8'h14;
	localparam logic [7:0] OFS_RDATA = 8'h18;
	localparam logic [7:0] OFS_STAT = 8'h1C;

	// ****************************************************************
	// timing register fields, one register per select space
	// ****************************************************************
	localparam int TF_RS_LSB = 0;
	localparam int TF_RST_LSB = 4;
	localparam int TF_RH_LSB = 10;
	localparam int TF_WS_LSB = 16;
	localparam int TF_WST_LSB = 20;
	localparam int TF_WH_LSB = 26;
	localparam int TF_RDY_BIT = 31;
	localparam int SETUP_W = 4;
	localparam int STROBE_W = 6;
	localparam int HOLD_W = 3;
	localparam logic [31:0] TIM_RST = 32'h0441_0441;

	// ****************************************************************
	// command and status fields
	// ****************************************************************
	localparam int CF_WRITE_BIT = 0;
	localparam int CF_ADDR_LSB = 2;
	localparam int CF_SPACE_LSB = 8;
	localparam int SF_BUSY_BIT = 0;
	localparam int SF_RDY_BIT = 1;
	localparam int SPACE_CNT = 4;

	// ****************************************************************
	// timing constants and response codes
	// ****************************************************************
	localparam logic [5:0] EXT_MIN_SUM = 6'h04;
	localparam logic [5:0] CNT_ONE = 6'h01;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0]
	{
		APSS_IDLE = 3'h0,
		APSS_SETUP = 3'h1,
		APSS_STRB = 3'h2,
		APSS_WAIT = 3'h3,
		APSS_HOLD = 3'h4
	} apss_phase_t;

endpackage

/* File: hdl/apss_sync.sv */
// module: two-stage synchroniser for the peripheral ready input
`timescale 1ns/100ps
`default_nettype none
module apss_sync
(
	// clock, reset and enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// level crossing
	input wire logic async_in,
	output logic sync_out
);
	import apss_pkg::*;

	typedef struct packed
	{
		logic ff1;
		logic ff2;
	} apss_sync_t;

	apss_sync_t s_r;
	apss_sync_t s_nxt;

	// first stage feeds only the second stage
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.ff1 = async_in;
		s_nxt.ff2 = s_r.ff1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_r <= '0;
		else if (ce)
			s_r <= s_nxt;
	end

	assign sync_out = s_r.ff2;
endmodule
`default_nettype wire

/* File: hdl/apss_top.sv */
// module: asynchronous peripheral strobe sequencer with AXI4-Lite register access
`timescale 1ns/100ps
`default_nettype none
module apss_top
(
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// axi4-lite write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// expansion bus pins
	output logic [apss_pkg::SPACE_CNT-1:0] space_select_n,
	output logic [3:0] byte_enable_or_word_address,
	output logic output_enable_n,
	output logic read_strobe_n,
	output logic write_strobe_or_wait_pin_n,
	input wire logic peripheral_ready,
	input wire logic [31:0] expansion_data_bus_i,
	output logic [31:0] expansion_data_bus_o,
	output logic expansion_data_bus_oe_n
);
	import apss_pkg::*;

	typedef struct packed
	{
		apss_phase_t st;
		logic [5:0] cnt;
		logic [SPACE_CNT-1:0][31:0] tim;
		logic [31:0] cur;
		logic wr;
		logic [3:0] addr;
		logic [1:0] space;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rd_bus;
		logic [1:0] rresp;
		logic [SPACE_CNT-1:0] cs_n;
		logic oe_n;
		logic re_n;
		logic we_n;
		logic d_oe_n;
	} apss_state_t;

	apss_state_t s_r;
	apss_state_t s_nxt;
	logic rdy_s;

	// ****************************************************************
	// ready synchroniser
	// ****************************************************************
	apss_sync u_rdy_sync
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.async_in(peripheral_ready),
		.sync_out(rdy_s)
	);

	// ****************************************************************
	// timing field helpers
	// ****************************************************************
	function automatic logic [5:0] f_setup(input logic [31:0] t, input logic w);
		f_setup = w ? 6'(t[TF_WS_LSB +: SETUP_W]) : 6'(t[TF_RS_LSB +: SETUP_W]);
	endfunction

	// a zero strobe count still yields one low cycle
	function automatic logic [5:0] f_strobe(input logic [31:0] t, input logic w);
		logic [5:0] v;
		v = w ? t[TF_WST_LSB +: STROBE_W] : t[TF_RST_LSB +: STROBE_W];
		f_strobe = (v == 6'h00) ? CNT_ONE : v;
	endfunction

	function automatic logic [5:0] f_hold(input logic [31:0] t, input logic w);
		f_hold = w ? 6'(t[TF_WH_LSB +: HOLD_W]) : 6'(t[TF_RH_LSB +: HOLD_W]);
	endfunction

	function automatic logic [31:0] f_merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] b);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
		begin
			if (b[i])
				r[8*i +: 8] = d[8*i +: 8];
		end
		f_merge = r;
	endfunction

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb
	begin
		logic [5:0] su;
		logic [5:0] sb;
		logic [5:0] hd;
		logic ext_ok;
		logic done;
		logic [31:0] t;
		su = f_setup(s_r.cur, s_r.wr);
		sb = f_strobe(s_r.cur, s_r.wr);
		hd = f_hold(s_r.cur, s_r.wr);
		// ready extension stays off when setup plus strobe is too short
		// sum taken one bit wider so a long setup plus strobe cannot wrap below the minimum
		ext_ok = s_r.cur[TF_RDY_BIT] && ((7'(su) + 7'(sb)) >= 7'(EXT_MIN_SUM));
		done = 1'b0;
		t = '0;
		s_nxt = s_r;

		// axi write: address and data taken in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			s_nxt.w_got = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready)
			s_nxt.bvalid = 1'b0;
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
		begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = RESP_OKAY;
			unique case ({s_r.aw_addr[7:2], 2'b00})
				OFS_TIM0, OFS_TIM1, OFS_TIM2, OFS_TIM3:
					s_nxt.tim[s_r.aw_addr[3:2]] = f_merge(s_r.tim[s_r.aw_addr[3:2]], s_r.w_data, s_r.w_strb);
				OFS_WDATA:
					s_nxt.wdata = f_merge(s_r.wdata, s_r.w_data, s_r.w_strb);
				OFS_CMD:
				begin
					// a command while busy is dropped; software polls the busy bit
					if (s_r.st == APSS_IDLE && s_r.w_strb[0])
					begin
						t = s_r.tim[s_r.w_data[CF_SPACE_LSB +: 2]];
						s_nxt.cur = t;
						s_nxt.wr = s_r.w_data[CF_WRITE_BIT];
						s_nxt.addr = s_r.w_data[CF_ADDR_LSB +: 4];
						s_nxt.space = s_r.w_data[CF_SPACE_LSB +: 2];
						if (f_setup(t, s_r.w_data[CF_WRITE_BIT]) != 6'h00)
						begin
							s_nxt.st = APSS_SETUP;
							s_nxt.cnt = f_setup(t, s_r.w_data[CF_WRITE_BIT]) - CNT_ONE;
						end
						else
						begin
							s_nxt.st = APSS_STRB;
							s_nxt.cnt = f_strobe(t, s_r.w_data[CF_WRITE_BIT]) - CNT_ONE;
						end
					end
				end
				OFS_RDATA, OFS_STAT:
					s_nxt.bresp = RESP_OKAY;
				default:
					s_nxt.bresp = RESP_SLVERR;
			endcase
		end

		// axi read
		if (s_r.rvalid && s_axi_rready)
			s_nxt.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = RESP_OKAY;
			unique case ({s_axi_araddr[7:2], 2'b00})
				OFS_TIM0, OFS_TIM1, OFS_TIM2, OFS_TIM3:
					s_nxt.rd_bus = s_r.tim[s_axi_araddr[3:2]];
				OFS_CMD:
					s_nxt.rd_bus = {22'h0, s_r.space, 2'h0, s_r.addr, 1'b0, s_r.wr};
				OFS_WDATA:
					s_nxt.rd_bus = s_r.wdata;
				OFS_RDATA:
					s_nxt.rd_bus = s_r.rdata;
				OFS_STAT:
					s_nxt.rd_bus = {30'h0, rdy_s, s_r.st != APSS_IDLE};
				default:
				begin
					s_nxt.rd_bus = 32'h0000_0000;
					s_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end

		// access sequencer
		unique case (s_r.st)
			APSS_IDLE:
				s_nxt.cnt = s_nxt.cnt;
			APSS_SETUP:
			begin
				s_nxt.cnt = s_r.cnt - CNT_ONE;
				if (s_r.cnt == 6'h00)
				begin
					s_nxt.st = APSS_STRB;
					s_nxt.cnt = sb - CNT_ONE;
				end
			end
			APSS_STRB:
			begin
				s_nxt.cnt = s_r.cnt - CNT_ONE;
				if (s_r.cnt == 6'h00)
				begin
					if (ext_ok && !rdy_s)
						s_nxt.st = APSS_WAIT;
					else
						done = 1'b1;
				end
			end
			APSS_WAIT:
				done = rdy_s;
			APSS_HOLD:
			begin
				s_nxt.cnt = s_r.cnt - CNT_ONE;
				if (s_r.cnt == 6'h00)
					s_nxt.st = APSS_IDLE;
			end
			default:
				s_nxt.st = APSS_IDLE;
		endcase
		if (done)
		begin
			// registered strobe rises on this edge, so the pins are sampled here
			if (!s_r.wr)
				s_nxt.rdata = expansion_data_bus_i;
			s_nxt.st = (hd != 6'h00) ? APSS_HOLD : APSS_IDLE;
			s_nxt.cnt = hd - CNT_ONE;
		end

		// pin levels follow the next phase so they stay glitch free
		s_nxt.cs_n = '1;
		s_nxt.oe_n = 1'b1;
		s_nxt.re_n = 1'b1;
		s_nxt.we_n = 1'b1;
		s_nxt.d_oe_n = 1'b1;
		if (s_nxt.st != APSS_IDLE)
		begin
			// space select released with the other selects, inside the allowed tail
			s_nxt.cs_n[s_nxt.space] = 1'b0;
			s_nxt.oe_n = s_nxt.wr;
			s_nxt.d_oe_n = !s_nxt.wr;
			if (s_nxt.st == APSS_STRB || s_nxt.st == APSS_WAIT)
			begin
				s_nxt.re_n = s_nxt.wr;
				s_nxt.we_n = !s_nxt.wr;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_r <= '0;
			s_r.st <= APSS_IDLE;
			s_r.tim <= {SPACE_CNT{TIM_RST}};
			s_r.cs_n <= '1;
			s_r.oe_n <= 1'b1;
			s_r.re_n <= 1'b1;
			s_r.we_n <= 1'b1;
			s_r.d_oe_n <= 1'b1;
		end
		else if (ce)
			s_r <= s_nxt;
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
	assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = !s_r.rvalid;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rd_bus;
	assign s_axi_rresp = s_r.rresp;
	assign space_select_n = s_r.cs_n;
	assign byte_enable_or_word_address = s_r.addr;
	assign output_enable_n = s_r.oe_n;
	assign read_strobe_n = s_r.re_n;
	assign write_strobe_or_wait_pin_n = s_r.we_n;
	assign expansion_data_bus_o = s_r.wdata;
	assign expansion_data_bus_oe_n = s_r.d_oe_n;

	// ****************************************************************
	// checks
	// ****************************************************************
	logic sel_act;
	logic strb_low;
	logic [6:0] sel_age;
	logic [6:0] low_age;
	logic [6:0] post_age;
	assign sel_act = !(&s_r.cs_n);
	assign strb_low = !(s_r.re_n && s_r.we_n);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sel_age <= 7'h00;
			low_age <= 7'h00;
			post_age <= 7'h00;
		end
		else if (ce)
		begin
			sel_age <= sel_act ? sel_age + 7'h01 : 7'h00;
			low_age <= strb_low ? low_age + 7'h01 : 7'h00;
			post_age <= (sel_act && !strb_low) ? post_age + 7'h01 : 7'h00;
		end
	end

	sequence seq_low_two_then_high;
		##1 strb_low [*2] ##1 !strb_low;
	endsequence

	sequence seq_ready_edge_waiting;
		s_r.st == APSS_WAIT && peripheral_ready && !$past(peripheral_ready);
	endsequence

	a_read_setup_lead: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		$fell(s_r.re_n) |-> sel_age >= 7'(f_setup(s_r.cur, 1'b0)))
		else $error("read strobe fell before setup elapsed");
	a_write_setup_lead: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		$fell(s_r.we_n) |-> sel_age >= 7'(f_setup(s_r.cur, 1'b1)))
		else $error("write strobe fell before setup elapsed");
	a_read_strobe_width: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		$rose(s_r.re_n) && !$past(s_r.st == APSS_WAIT) |-> low_age == 7'(f_strobe(s_r.cur, 1'b0)))
		else $error("read strobe width differs from count");
	a_write_strobe_width: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		$rose(s_r.we_n) && !$past(s_r.st == APSS_WAIT) |-> low_age == 7'(f_strobe(s_r.cur, 1'b1)))
		else $error("write strobe width differs from count");
	a_select_hold_time: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		$fell(sel_act) |-> post_age >= 7'(f_hold(s_r.cur, s_r.wr)))
		else $error("selects released before hold elapsed");
	a_ready_release_delay: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		seq_ready_edge_waiting |-> seq_low_two_then_high)
		else $error("strobe not released three cycles after ready");
	a_write_data_drive: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		!s_r.d_oe_n |-> sel_act && s_r.oe_n && s_r.re_n)
		else $error("data bus driven outside a write access");
	a_read_data_capture: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		$rose(s_r.re_n) |-> s_r.rdata == $past(expansion_data_bus_i))
		else $error("read data not captured at strobe rise");
	a_single_strobe_phase: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		strb_low |-> sel_act && !(s_r.re_n == 1'b0 && s_r.we_n == 1'b0))
		else $error("strobe low outside an access or both low");
	a_bresp_stable_wait: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		s_r.bvalid && !s_axi_bready |=> s_r.bvalid && $stable(s_r.bresp))
		else $error("write response dropped before taken");
endmodule
`default_nettype wire

/* File: sim/apss_periph.sv */
// partner model: asynchronous peripheral with a small word store and a ready output
`timescale 1ns/100ps
`default_nettype none
module apss_periph
(
	// clock
	input wire logic aclk,
	// expansion bus from the sequencer
	input wire logic [3:0] space_select_n,
	input wire logic [3:0] word_addr,
	input wire logic output_enable_n,
	input wire logic write_strobe_n,
	input wire logic [31:0] data_o,
	input wire logic data_oe_n,
	// answer to the sequencer
	output logic [31:0] data_i,
	output logic ready,
	// cycles to hold ready low, from the bench
	input wire logic [7:0] wait_cyc
);
	// known contents so a read of an unwritten word still returns a defined value
	logic [31:0] mem [16] = '{default: 32'h5A5A_5A5A};
	logic [31:0] last = 32'h0;
	logic [7:0] cnt = 8'h0;
	logic idle_q = 1'b1;
	logic wstb_q = 1'b1;
	initial ready = 1'b1;
	// a released bus shows the inverse of its last value so a stale copy cannot pass
	assign data_i = !output_enable_n ? mem[word_addr] : ~last;
	always @(posedge aclk)
	begin
		last <= data_i;
		idle_q <= &space_select_n;
		wstb_q <= write_strobe_n;
		if (idle_q && !(&space_select_n))
		begin
			// level chosen on the first edge that sees a select low, and held until the wait ends
			ready <= (wait_cyc == 8'h0);
			cnt <= wait_cyc;
		end
		else if (cnt != 8'h0)
		begin
			cnt <= cnt - 8'h1;
			// once high, ready stays high until the next access
			if (cnt == 8'h1)
				ready <= 1'b1;
		end
		if (!wstb_q && write_strobe_n && !data_oe_n)
			mem[word_addr] <= data_o;
	end
endmodule
`default_nettype wire

/* File: sim/apss_top_tb.sv */
// testbench: register access, timed read and write cycles, ready stretching
`timescale 1ns/100ps
`default_nettype none
module apss_top_tb;
	import apss_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00, wt = 8'h00;
	logic [31:0] wd = 32'h0;
	logic awr, wr_, bv, arr, rv, oe_n, rstb_n, wstb_n, rdy, doe_n, stb;
	logic [1:0] br, rr, r;
	logic [31:0] rd, di, dq, v;
	logic [3:0] cs_n, wa;
	logic act = 1'b0, ph = 1'b0;
	logic [7:0] su = 8'h0, sw = 8'h0, ho = 8'h0, rc = 8'h0, r_su, r_sw, r_ho, r_rc;
	logic [11:0] m_pins;
	logic [31:0] m_dq;
	int err_count = 0;
	int samples_checked = 0;
	assign stb = rstb_n & wstb_n;

	apss_top dut
	(
		.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
		.space_select_n(cs_n), .byte_enable_or_word_address(wa), .output_enable_n(oe_n),
		.read_strobe_n(rstb_n), .write_strobe_or_wait_pin_n(wstb_n), .peripheral_ready(rdy),
		.expansion_data_bus_i(di), .expansion_data_bus_o(dq), .expansion_data_bus_oe_n(doe_n)
	);

	apss_periph peri
	(
		.aclk(aclk), .space_select_n(cs_n), .word_addr(wa), .output_enable_n(oe_n),
		.write_strobe_n(wstb_n), .data_o(dq), .data_oe_n(doe_n), .data_i(di), .ready(rdy),
		.wait_cyc(wt)
	);

	initial
	begin
		forever #2.5 aclk = ~aclk;
	end

	// ****************************************************************
	// pin monitor: setup, strobe and hold lengths in sampled cycles
	// ****************************************************************
	always @(posedge aclk)
	begin
		if (cs_n != 4'hF)
		begin
			act <= 1'b1;
			if (!stb)
			begin
				sw <= sw + 8'h1;
				ph <= 1'b1;
				m_pins <= {cs_n, wa, rstb_n, wstb_n, oe_n, doe_n};
				m_dq <= dq;
				if (rdy)
					rc <= rc + 8'h1;
			end
			else if (!ph)
				su <= su + 8'h1;
			else
				ho <= ho + 8'h1;
		end
		else if (act)
		begin
			{r_su, r_sw, r_ho, r_rc} <= {su, sw, ho, rc};
			{act, ph, su, sw, ho, rc} <= '0;
		end
	end

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tmo(input int n);
		if (n >= 40)
		begin
			err_count++;
			finish_test();
		end
	endtask

	function automatic logic [31:0] tim(input int rs, rst, rh, ws, write_strobe_count, wh, rdy_en);
		return 32'(rs << TF_RS_LSB | rst << TF_RST_LSB | rh << TF_RH_LSB | ws << TF_WS_LSB
			| write_strobe_count << TF_WST_LSB | wh << TF_WH_LSB | rdy_en << TF_RDY_BIT);
	endfunction

	// handshakes are judged at the rising edge, on the values the slave samples there
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic [1:0] rb;
		rb = 2'h3;
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wr_)
				wv <= 1'b0;
			if (bre && bv)
			begin
				rb = br;
				break;
			end
		end
		tmo(n);
		bre <= 1'b0;
		chk(32'(rb), 32'(er));
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
		int n;
		d = 32'h0;
		rsp = 2'h3;
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (arv && arr)
				arv <= 1'b0;
			if (rre && rv)
			begin
				d = rd;
				rsp = rr;
				break;
			end
		end
		tmo(n);
		rre <= 1'b0;
	endtask

	// start one access, wait for it to finish, compare the measured pin timing
	task automatic acc(input int sp, ad, w, t, esu, esw, eho, input logic [31:0] d);
		int n;
		logic [31:0] s;
		logic [1:0] q;
		wt <= 8'(t);
		axi_wr(OFS_CMD, 32'(w | ad << CF_ADDR_LSB | sp << CF_SPACE_LSB), RESP_OKAY);
		s = 32'h1;
		for (n = 0; n < 40 && s[SF_BUSY_BIT] === 1'b1; n++)
			axi_rd(OFS_STAT, s, q);
		tmo(n);
		chk(32'(r_su), 32'(esu));
		if (esw > 0)
			chk(32'(r_sw), 32'(esw));
		chk(32'(r_ho), 32'(eho));
		chk(32'(m_pins), 32'({~(4'h1 << sp), 4'(ad), w ? 4'hA : 4'h5}));
		if (w)
			chk(m_dq, d);
	endtask

	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(OFS_TIM0, v, r);
		chk(v, TIM_RST);
		axi_rd(OFS_STAT, v, r);
		chk(v, 32'(1 << SF_RDY_BIT));
		axi_rd(8'h40, v, r);
		chk(32'(r), 32'(RESP_SLVERR));
		axi_wr(8'h44, 32'h1, RESP_SLVERR);
		axi_wr(OFS_TIM1, tim(2, 5, 3, 1, 3, 2, 0), RESP_OKAY);
		axi_wr(OFS_WDATA, 32'hA5C3_0F96, RESP_OKAY);
		acc(1, 5, 1, 0, 1, 3, 2, 32'hA5C3_0F96);
		acc(1, 5, 0, 0, 2, 5, 3, 32'h0);
		axi_wr(OFS_RDATA, 32'h0, RESP_OKAY);
		axi_rd(OFS_RDATA, v, r);
		chk(v, 32'hA5C3_0F96);
		acc(0, 10, 1, 0, 1, 4, 1, 32'hA5C3_0F96);
		// ready held low well past the programmed strobe stretches both kinds of cycle
		axi_wr(OFS_TIM2, tim(1, 3, 1, 2, 2, 1, 1), RESP_OKAY);
		acc(2, 3, 0, 10, 1, 0, 1, 32'h0);
		chk(32'(r_sw > 8'h3), 32'h1);
		chk(32'(r_rc >= 8'h3 && r_rc <= 8'h4), 32'h1);
		acc(2, 3, 1, 10, 2, 0, 1, 32'hA5C3_0F96);
		chk(32'(r_rc >= 8'h3 && r_rc <= 8'h4), 32'h1);
		// setup plus strobe below four: ready is ignored
		axi_wr(OFS_TIM3, tim(0, 3, 1, 1, 2, 1, 1), RESP_OKAY);
		acc(3, 15, 0, 10, 0, 3, 1, 32'h0);
		axi_rd(OFS_RDATA, v, r);
		chk(v, 32'h5A5A_5A5A);
		finish_test();
	end
endmodule
`default_nettype wire
